// File: core/isp_defs.svh
/*
 * Shared constants of the serial programming link: memory geometry,
 * frame field positions, erased value, timing figures and the cycle
 * counts derived from them. Assumes a 40 MHz core clock on both ends.
 */
// Contract
// - flash is 1024 words of 16 bits
// - eeprom is 128 separate byte-wide locations
// - flash 0000-03FF, eeprom 000-07F, independent
// - eeprom byte write self-timed, erases itself
// - bulk erase sets flash and eeprom to FF
// - device samples programmer data on SCK rise
// - device shifts read data on SCK fall
// - SCK low and high over 2 core cycles
// - reset and SCK held low at power-up
// - external core clock 0-8 MHz if selected
// - wait 20 ms before enabling programming
// - instructions are 4-byte frames, decoded whole; reads are decoded after the first three bytes
`ifndef ISP_DEFS_SVH
`define ISP_DEFS_SVH

// ==================================================================
// geometry
`define ISP_FLASH_WORDS    1024
`define ISP_EE_BYTES       128
`define ISP_FLASH_ADDR_MAX 10'h03ff
`define ISP_EE_ADDR_MAX    10'h007f
`define ISP_ERASED_BYTE    8'hff
`define ISP_ERASED_WORD    16'hffff

// ==================================================================
// frame layout, bit 31 is sent first
`define ISP_FRAME_BITS     32
`define ISP_F_CMD_MSB      31
`define ISP_F_CMD_LSB      24
`define ISP_F_B1_MSB       23
`define ISP_F_B1_LSB       16
`define ISP_F_B2_MSB       15
`define ISP_F_B2_LSB       8
`define ISP_F_DATA_MSB     7
`define ISP_ENABLE_KEY     8'h5a

// ==================================================================
// timing
`define ISP_MCLK_PERIOD_NS 25
`define ISP_MCLK_KHZ       40000
`define ISP_WRITE_NS       4000
`define ISP_ERASE_NS       9000
`define ISP_WRITE_CYC \
    ((`ISP_WRITE_NS + `ISP_MCLK_PERIOD_NS - 1) / `ISP_MCLK_PERIOD_NS)
`define ISP_ERASE_CYC \
    ((`ISP_ERASE_NS + `ISP_MCLK_PERIOD_NS - 1) / `ISP_MCLK_PERIOD_NS)
`define ISP_POWERUP_MS     20
`define ISP_POWERUP_CYC    (`ISP_POWERUP_MS * `ISP_MCLK_KHZ)
`define ISP_SCK_PERIOD_NS  200
`define ISP_SCK_HALF_CYC   ((`ISP_SCK_PERIOD_NS / 2) / `ISP_MCLK_PERIOD_NS)

`endif

// File: core/isp_pkg.sv
/*
 * Types of the serial programming link: instruction codes, the
 * programmer's sequencer states and data widths.
 * Holds its own numeric codes and takes nothing from isp_defs.svh.
 */
package isp_pkg;

    typedef logic [7:0]  byte_t;
    typedef logic [15:0] word_t;
    typedef logic [9:0]  addr_t;
    typedef logic [31:0] frame_t;

    typedef enum logic [7:0] {
        cmd_enable   = 8'h01,
        cmd_erase    = 8'h02,
        cmd_rd_fl_lo = 8'h10,
        cmd_rd_fl_hi = 8'h11,
        cmd_rd_ee    = 8'h12,
        cmd_wr_fl_lo = 8'h20,
        cmd_wr_fl_hi = 8'h21,
        cmd_wr_ee    = 8'h22
    } cmd_e;

    typedef enum logic [1:0] {
        hs_wait = 2'h0,
        hs_idle = 2'h1,
        hs_low  = 2'h2,
        hs_high = 2'h3
    } host_state_e;

endpackage

// File: core/isp_if.sv
/*
 * Pins between the programmer and the target. The read-back line is
 * driven by the target only while its enable is high; otherwise a
 * pull-up holds it high.
 */
`timescale 1ns/1ps
interface isp_if;
    logic sck;
    logic mosi;
    logic prog_rst_n;
    logic miso_o;
    logic miso_oe;
    logic miso;

    assign miso = miso_oe ? miso_o : 1'h1;

    modport target (
        input  sck,
        input  mosi,
        input  prog_rst_n,
        output miso_o,
        output miso_oe
    );
    modport programmer (
        output sck,
        output mosi,
        output prog_rst_n,
        input  miso
    );
endinterface

// File: core/isp_target.sv
/*
 * Target end of the serial programming link: pin synchronisers, frame
 * shifter, instruction decode, flash and eeprom arrays in flip-flops,
 * self-timed write and erase.
 * Assumes the programmer keeps each SCK phase over two core cycles and
 * drives the reset pin low for the whole programming session.
 */
`timescale 1ns/1ps
`include "isp_defs.svh"
module isp_target (
    input  wire logic   i_mclk,
    input  wire logic   i_resetn,
    isp_if.target       link,
    output logic        o_prog_mode,
    output logic        o_busy,
    output isp_pkg::cmd_e o_last_cmd
);
    import isp_pkg::*;

    // ==================================================================
    // pin synchronisers
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic       sck_prev_q;
    logic       sck_rise;
    logic       sck_fall;
    logic       in_prog;
    logic       mosi_bit;

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_q     <= 3'h4;
            sync_q     <= 3'h4;
            sck_prev_q <= 1'h0;
        end else begin
            meta_q     <= {link.prog_rst_n, link.mosi, link.sck};
            sync_q     <= meta_q;
            sck_prev_q <= sync_q[0];
        end
    end

    // edges are seen two cycles late; both phases must outlast that
    assign sck_rise = sync_q[0] & ~sck_prev_q;
    assign sck_fall = ~sync_q[0] & sck_prev_q;
    assign mosi_bit = sync_q[1];
    assign in_prog  = ~sync_q[2];

    // ==================================================================
    // frame shifter
    logic [4:0] bit_cnt_q;
    frame_t     rx_q;
    frame_t     rx_next;
    logic       frame_done;
    logic       byte_done;

    assign rx_next    = {rx_q[30:0], mosi_bit};
    assign frame_done = sck_rise && (bit_cnt_q == 5'h1f);
    assign byte_done  = sck_rise && (bit_cnt_q[2:0] == 3'h7);

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            bit_cnt_q <= 5'h00;
            rx_q      <= 32'h0000_0000;
        end else if (!in_prog) begin
            bit_cnt_q <= 5'h00;
            rx_q      <= 32'h0000_0000;
        end else if (sck_rise) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;     // wraps after 32 bits
            rx_q      <= rx_next;
        end
    end

    // ==================================================================
    // decode
    function automatic addr_t addr_of(input logic [15:0] b12);
        return b12[9:0];
    endfunction

    cmd_e  act_cmd;
    addr_t act_addr;
    byte_t act_data;
    byte_t act_key;
    cmd_e  pre_cmd;
    addr_t pre_addr;

    // whole frame, valid together with frame_done
    assign act_cmd  = cmd_e'(rx_next[`ISP_F_CMD_MSB:`ISP_F_CMD_LSB]);
    assign act_key  = rx_next[`ISP_F_B1_MSB:`ISP_F_B1_LSB];
    assign act_addr = addr_of(rx_next[`ISP_F_B1_MSB:`ISP_F_B2_LSB]);
    assign act_data = rx_next[`ISP_F_DATA_MSB:0];
    // first three bytes, valid at the 24th rising edge
    assign pre_cmd  = cmd_e'(rx_next[23:16]);
    assign pre_addr = addr_of(rx_next[15:0]);

    // ==================================================================
    // programming enable
    logic en_q;
    logic busy_q;
    logic do_write;
    logic do_erase;
    logic ee_ok;

    assign ee_ok    = act_addr <= `ISP_EE_ADDR_MAX;
    assign do_erase = frame_done && en_q && !busy_q
                      && (act_cmd == cmd_erase);
    assign do_write = frame_done && en_q && !busy_q
                      && ((act_cmd == cmd_wr_fl_lo)
                          || (act_cmd == cmd_wr_fl_hi)
                          || ((act_cmd == cmd_wr_ee) && ee_ok));

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            en_q <= 1'h0;
        end else if (!in_prog) begin
            en_q <= 1'h0;
        end else if (frame_done && (act_cmd == cmd_enable)
                     && (act_key == `ISP_ENABLE_KEY)) begin
            en_q <= 1'h1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_last_cmd <= cmd_enable;
        end else if (do_write || do_erase) begin
            o_last_cmd <= act_cmd;
        end
    end

    // ==================================================================
    // self-timed write and erase
    logic [15:0] busy_cnt_q;

    // a write or erase frame that arrives while busy is dropped, not queued
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            busy_cnt_q <= 16'h0000;
            busy_q     <= 1'h0;
        end else if (do_erase) begin
            busy_cnt_q <= 16'(`ISP_ERASE_CYC);
            busy_q     <= 1'h1;
        end else if (do_write) begin
            busy_cnt_q <= 16'(`ISP_WRITE_CYC);
            busy_q     <= 1'h1;
        end else if (busy_q) begin
            busy_cnt_q <= busy_cnt_q - 16'h0001;
            busy_q     <= (busy_cnt_q != 16'h0001);
        end
    end

    // ==================================================================
    // storage arrays, contents survive reset
    word_t flash_q [`ISP_FLASH_WORDS];
    byte_t ee_q    [`ISP_EE_BYTES];

    always_ff @(posedge i_mclk) begin
        if (do_erase) begin
            for (int i = 0; i < `ISP_FLASH_WORDS; i++) begin
                flash_q[i] <= `ISP_ERASED_WORD;
            end
            for (int j = 0; j < `ISP_EE_BYTES; j++) begin
                ee_q[j] <= `ISP_ERASED_BYTE;
            end
        end else if (do_write) begin
            unique case (act_cmd)
                cmd_wr_fl_lo: begin
                    flash_q[act_addr][7:0] <= act_data;
                end
                cmd_wr_fl_hi: begin
                    flash_q[act_addr][15:8] <= act_data;
                end
                cmd_wr_ee: begin
                    // replaces the old byte, no prior erase needed
                    ee_q[act_addr[6:0]] <= act_data;
                end
                default: begin
                end
            endcase
        end
    end

    function automatic byte_t rd_byte(input cmd_e c, input addr_t a);
        byte_t r;
        r = 8'h00;
        unique case (c)
            cmd_rd_fl_lo: r = flash_q[a][7:0];
            cmd_rd_fl_hi: r = flash_q[a][15:8];
            cmd_rd_ee: begin
                if (a <= `ISP_EE_ADDR_MAX) begin
                    r = ee_q[a[6:0]];
                end
            end
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    // ==================================================================
    // read-back shifter
    byte_t tx_q;
    logic  miso_q;
    logic  miso_oe_q;
    logic  is_read;

    assign is_read = (pre_cmd == cmd_rd_fl_lo) || (pre_cmd == cmd_rd_fl_hi)
                     || (pre_cmd == cmd_rd_ee);

    // each byte echoes the previous one; the fourth carries read data
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            tx_q <= 8'h00;
        end else if (!in_prog) begin
            tx_q <= 8'h00;
        end else if (byte_done) begin
            if ((bit_cnt_q == 5'h17) && en_q && is_read) begin
                tx_q <= rd_byte(pre_cmd, pre_addr);
            end else begin
                tx_q <= rx_next[7:0];
            end
        end else if (sck_fall) begin
            tx_q <= {tx_q[6:0], 1'h0};
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            miso_q    <= 1'h0;
            miso_oe_q <= 1'h0;
        end else begin
            miso_oe_q <= in_prog;
            if (!in_prog) begin
                miso_q <= 1'h0;
            end else if (sck_fall) begin
                miso_q <= tx_q[7];
            end
        end
    end

    assign link.miso_o  = miso_q;
    assign link.miso_oe = miso_oe_q;

    // ==================================================================
    // status
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_prog_mode <= 1'h0;
            o_busy      <= 1'h0;
        end else begin
            o_prog_mode <= en_q;
            o_busy      <= busy_q;
        end
    end

endmodule

// File: core/isp_programmer.sv
/*
 * Programmer end of the serial programming link: power-up hold, SCK
 * divider and a 32-bit frame shifter driven by a user request port.
 * Assumes the target runs from a core clock of at least 40 MHz so each
 * SCK phase of four cycles outlasts two target core cycles.
 */
`timescale 1ns/1ps
`include "isp_defs.svh"
module isp_programmer #(
    parameter int unsigned POWERUP_CYC = `ISP_POWERUP_CYC
) (
    input  wire logic            i_mclk,
    input  wire logic            i_resetn,
    isp_if.programmer            link,
    input  wire logic            i_start,
    input  wire isp_pkg::frame_t i_frame,
    input  wire logic            i_run,
    output logic                 o_ready,
    output logic                 o_done,
    output isp_pkg::frame_t      o_rframe
);
    import isp_pkg::*;

    // ==================================================================
    // read-back synchroniser
    logic miso_meta_q;
    logic miso_s_q;

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            miso_meta_q <= 1'h1;
            miso_s_q    <= 1'h1;
        end else begin
            miso_meta_q <= link.miso;
            miso_s_q    <= miso_meta_q;
        end
    end

    // ==================================================================
    // sequencer
    host_state_e state_q;
    logic [19:0] wait_q;
    logic [2:0]  div_q;
    logic [4:0]  bits_q;
    frame_t      sh_q;
    frame_t      rx_q;
    logic        sck_q;
    logic        mosi_q;
    logic        rst_n_q;
    logic        half_end;

    assign half_end = (div_q == 3'(`ISP_SCK_HALF_CYC - 1));

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_n_q <= 1'h0;
        end else begin
            rst_n_q <= i_run;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q  <= hs_wait;
            wait_q   <= 20'h0_0000;
            div_q    <= 3'h0;
            bits_q   <= 5'h00;
            sh_q     <= 32'h0000_0000;
            rx_q     <= 32'h0000_0000;
            sck_q    <= 1'h0;
            mosi_q   <= 1'h0;
            o_ready  <= 1'h0;
            o_done   <= 1'h0;
            o_rframe <= 32'h0000_0000;
        end else begin
            o_done <= 1'h0;
            unique case (state_q)
                hs_wait: begin
                    if (wait_q == 20'(POWERUP_CYC - 1)) begin
                        state_q <= hs_idle;
                        o_ready <= 1'h1;
                    end else begin
                        wait_q <= wait_q + 20'h0_0001;
                    end
                end
                hs_idle: begin
                    if (i_start && !i_run) begin
                        sh_q    <= i_frame;
                        mosi_q  <= i_frame[31];
                        bits_q  <= 5'h00;
                        div_q   <= 3'h0;
                        o_ready <= 1'h0;
                        state_q <= hs_low;
                    end
                end
                hs_low: begin
                    div_q <= div_q + 3'h1;
                    if (half_end) begin
                        div_q   <= 3'h0;
                        sck_q   <= 1'h1;
                        state_q <= hs_high;
                    end
                end
                hs_high: begin
                    div_q <= div_q + 3'h1;
                    if (half_end) begin
                        // latest sample point, covers the target's lag
                        div_q <= 3'h0;
                        sck_q <= 1'h0;
                        rx_q  <= {rx_q[30:0], miso_s_q};
                        if (bits_q == 5'h1f) begin
                            o_rframe <= {rx_q[30:0], miso_s_q};
                            o_done   <= 1'h1;
                            o_ready  <= 1'h1;
                            state_q  <= hs_idle;
                        end else begin
                            bits_q  <= bits_q + 5'h01;
                            sh_q    <= {sh_q[30:0], 1'h0};
                            mosi_q  <= sh_q[30];
                            state_q <= hs_low;
                        end
                    end
                end
            endcase
        end
    end

    assign link.sck        = sck_q;
    assign link.mosi       = mosi_q;
    assign link.prog_rst_n = rst_n_q;

endmodule

// File: verification/isp_link_monitor.sv
/*
 * Checker of the serial programming link pins between the two ends.
 * Assumes both ends share i_mclk and i_resetn, and the programmer
 * keeps four core cycles in each serial clock phase.
 */
`timescale 1ns/1ps
module isp_link_monitor (
    input  wire logic i_mclk,
    input  wire logic i_resetn,
    input  wire logic sck,
    input  wire logic mosi,
    input  wire logic prog_rst_n,
    input  wire logic miso_o,
    input  wire logic miso_oe
);
    logic       sck_q;
    logic [4:0] rise_cnt_q;

    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    // ==============================================================
    // serial clock rises per session, kept modulo one frame
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            sck_q <= 1'h0;
        end else begin
            sck_q <= sck;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rise_cnt_q <= 5'h00;
        end else if (prog_rst_n) begin
            rise_cnt_q <= 5'h00;
        end else begin
            rise_cnt_q <= rise_cnt_q + {4'h0, sck && !sck_q};
        end
    end

    // ==============================================================
    // wire timing
    a_sck_low_time: assert property ($fell(sck) |-> !sck [*4])
        else $error("serial clock low phase too short");
    a_sck_high_time: assert property
        ($rose(sck) |-> sck [*4] ##1 !sck)
        else $error("serial clock high phase not four cycles");
    a_mosi_hold: assert property ($changed(mosi) |-> !sck)
        else $error("programmer data moved while clock high");
    a_miso_on_fall: assert property ($changed(miso_o) |-> !sck)
        else $error("read-back bit moved while clock high");
    a_sck_in_session: assert property (sck |-> !prog_rst_n)
        else $error("serial clock toggled outside a session");
    a_miso_release: assert property
        ($rose(prog_rst_n) |-> ##[1:6] !miso_oe)
        else $error("read-back line kept after session end");
    a_miso_drive: assert property
        ($fell(prog_rst_n) |-> ##[1:6] miso_oe)
        else $error("read-back line not driven in session");
    a_frame_length: assert property
        ($rose(prog_rst_n) |-> rise_cnt_q == 5'h00)
        else $error("session ended inside a frame");
endmodule

// File: verification/tb_serial_memory_programming.sv
/*
 * Testbench joining programmer and target through one link interface.
 * Assumes a 40 MHz core clock and a shortened power-up wait.
 */
`timescale 1ns/1ps
module tb_serial_memory_programming;
    import isp_pkg::*;

    logic   mclk;
    logic   resetn;
    logic   start;
    frame_t frame;
    logic   run;
    logic   ready;
    logic   done;
    frame_t rframe;
    logic   prog_mode;
    logic   busy;
    cmd_e   last_cmd;
    frame_t rf;
    int     bad_count;
    int     compares;
    addr_t  edge_a [2] = '{10'h000, 10'h3ff};

    isp_if link ();

    // short power-up wait keeps the run small
    isp_programmer #(.POWERUP_CYC(20)) isp_programmer_inst (
        .i_mclk(mclk), .i_resetn(resetn), .link(link),
        .i_start(start), .i_frame(frame), .i_run(run),
        .o_ready(ready), .o_done(done), .o_rframe(rframe));
    isp_target isp_target_inst (
        .i_mclk(mclk), .i_resetn(resetn), .link(link),
        .o_prog_mode(prog_mode), .o_busy(busy), .o_last_cmd(last_cmd));
    isp_link_monitor isp_link_monitor_inst (
        .i_mclk(mclk), .i_resetn(resetn), .sck(link.sck),
        .mosi(link.mosi), .prog_rst_n(link.prog_rst_n),
        .miso_o(link.miso_o), .miso_oe(link.miso_oe));

    // target and programmer both run from mclk, one shared core clock
    always #12.5 mclk = ~mclk;

    // ==============================================================
    // helpers
    task automatic complete_run();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string what);
        compares++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %0t ns: %s", $time, what);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wait_idle();
        for (int n = 0; n < 600 && busy !== 1'b0; n++) tick(1);
        check(busy === 1'b0, "busy never ended");
    endtask

    task automatic xfer(input byte_t c, b1, b2, d);
        for (int n = 0; n < 600 && ready !== 1'b1; n++) tick(1);
        frame = {c, b1, b2, d};
        start = 1'b1;
        tick(1);
        start = 1'b0;
        for (int n = 0; n < 400 && done !== 1'b1; n++) tick(1);
        check(done === 1'b1, "frame never finished");
        rf = rframe;
        tick(4);
    endtask

    task automatic wr(input byte_t c, input addr_t a, input byte_t d,
                      input logic act);
        xfer(c, {6'h00, a[9:8]}, a[7:0], d);
        check(busy === act, "busy state after write");
        wait_idle();
        if (act) check(last_cmd === c, "last command code");
    endtask

    task automatic rd(input byte_t c, input addr_t a, input byte_t exp);
        xfer(c, {6'h00, a[9:8]}, a[7:0], 8'h00);
        check(rf[23:8] === {c, 6'h00, a[9:8]}, "read-back echo");
        check(rf[7:0] === exp, "read data");
    endtask

    // ==============================================================
    // watchdog, far beyond the roughly 9k cycles the tests need
    initial begin
        #(40000 * 25);
        bad_count++;
        $display("[FAIL] %0t ns: watchdog expired", $time);
        complete_run();
    end

    // ==============================================================
    // tests
    initial begin
        mclk = 1'h0;
        resetn = 1'h0;
        start = 1'h0;
        frame = 32'h0000_0000;
        run = 1'h0;
        bad_count = 0;
        compares = 0;
        tick(20);
        resetn = 1'h1;
        tick(10);
        check(ready === 1'b0, "ready inside power-up wait");
        wr(cmd_wr_ee, 10'h000, 8'h66, 1'b0);
        xfer(cmd_enable, 8'h00, 8'h00, 8'h00);
        check(prog_mode === 1'b0, "enable taken without key");
        xfer(cmd_enable, 8'h5a, 8'h00, 8'h00);
        check(prog_mode === 1'b1, "enable refused");
        // write sent straight behind erase lands while still busy
        xfer(cmd_erase, 8'h00, 8'h00, 8'h00);
        xfer(cmd_wr_ee, 8'h00, 8'h01, 8'h44);
        wait_idle();
        check(last_cmd === cmd_erase, "erase not recorded");
        rd(cmd_rd_ee, 10'h001, 8'hff);
        foreach (edge_a[i]) begin
            rd(cmd_rd_fl_lo, edge_a[i], 8'hff);
            rd(cmd_rd_fl_hi, edge_a[i], 8'hff);
            rd(cmd_rd_ee, edge_a[i] & 10'h07f, 8'hff);
        end
        wr(cmd_wr_fl_lo, 10'h3ff, 8'ha5, 1'b1);
        wr(cmd_wr_fl_hi, 10'h3ff, 8'h3c, 1'b1);
        wr(cmd_wr_ee, 10'h07f, 8'h5c, 1'b1);
        wr(cmd_wr_ee, 10'h07f, 8'ha3, 1'b1);
        wr(cmd_wr_ee, 10'h000, 8'h12, 1'b1);
        wr(cmd_wr_ee, 10'h080, 8'h77, 1'b0);
        rd(cmd_rd_fl_lo, 10'h3ff, 8'ha5);
        rd(cmd_rd_fl_hi, 10'h3ff, 8'h3c);
        rd(cmd_rd_fl_lo, 10'h07f, 8'hff);
        rd(cmd_rd_fl_hi, 10'h000, 8'hff);
        rd(cmd_rd_ee, 10'h07f, 8'ha3);
        rd(cmd_rd_ee, 10'h000, 8'h12);
        rd(cmd_rd_ee, 10'h080, 8'h00);
        // reset pin pulse ends the session and drops the enable
        run = 1'h1;
        tick(8);
        check(prog_mode === 1'b0, "enable kept with pin high");
        run = 1'h0;
        tick(8);
        wr(cmd_wr_ee, 10'h000, 8'h99, 1'b0);
        xfer(cmd_enable, 8'h5a, 8'h00, 8'h00);
        rd(cmd_rd_ee, 10'h000, 8'h12);
        // core reset in mid-frame must not let a partial frame act
        frame = {cmd_wr_ee, 8'h00, 8'h00, 8'h55};
        start = 1'h1;
        tick(1);
        start = 1'h0;
        tick(100);
        resetn = 1'h0;
        tick(2);
        check(ready === 1'b0 && link.sck === 1'b0 && busy === 1'b0 &&
              prog_mode === 1'b0 && last_cmd === cmd_enable,
              "outputs not at reset values");
        resetn = 1'h1;
        xfer(cmd_enable, 8'h5a, 8'h00, 8'h00);
        rd(cmd_rd_ee, 10'h000, 8'h12);
        complete_run();
    end
endmodule
